// ===== byte_fifo.sv
`timescale 1ns/10ps
// small flop fifo; count tells full and empty honestly
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_state_t;
	fifo_state_t st_q, st_d;
	logic push;
	logic pop;
	// handshakes on both ends
	always_comb
	begin
		st_d = st_q;
		push = i_valid && (st_q.cnt != (AW+1)'(DEPTH));
		pop = i_ready && (st_q.cnt != '0);
		if (push)
		begin
			st_d.mem[st_q.wr] = i_data;
			st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
		end
		if (pop)
			st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (i_flush)
		begin
			st_d.wr = '0;
			st_d.rd = '0;
			st_d.cnt = '0;
		end
	end
	// register state
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign o_ready = st_q.cnt != (AW+1)'(DEPTH);
	assign o_valid = st_q.cnt != '0;
	assign o_data = st_q.mem[st_q.rd];
endmodule : byte_fifo

// ===== spi_far_slave.sv
`timescale 1ns/10ps
// behavioural far slave: takes mosi, answers on miso, timing set by phase
module spi_far_slave (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_sel_n,
	input wire logic i_cpha,
	input wire logic [7:0] i_tx,
	output logic o_miso,
	output logic [7:0] o_rx
);
	logic [7:0] sh_q = 8'h00; // outgoing byte, msb at the pin
	int edge_n = 0; // serial clock edges seen in this frame
	// frame start: reload, msb shows at once for phase zero
	always @(negedge i_sel_n)
	begin
		sh_q = i_tx;
		edge_n = 0;
	end
	// odd edges latch for phase zero, even edges for phase one
	always @(i_sck)
	begin
		if (!i_sel_n)
		begin
			edge_n++;
			if (edge_n[0] ^ i_cpha)
			begin
				o_rx = {o_rx[6:0], i_mosi};
			end
			else if (!i_cpha || edge_n > 1)
			begin
				sh_q = {sh_q[6:0], 1'b0};
			end
		end
	end
	// released line shows the inverse so a stale bit never matches
	assign o_miso = i_sel_n ? ~sh_q[7] : sh_q[7];
endmodule : spi_far_slave

// ===== spi_master_slave_port.sv
`timescale 1ns/10ps
// Summary of operation
// - bytes move msb first both directions
// - master clocks; slave answers on its output
// - master rate from 3-bit field, fastest /4
// - soft select replaces pin when managed
// - master and enable stay only with select high
// - phase zero: slave write mid-byte with select low, collision
// - master data write loads and starts shifting
// - done flag sets; irq gated by enable, mask
// - master clears done: status, then data read
// - slave clears done: status, then data access
// - data writes ignored while done until status read
// - slave write loads shifter, shifts on master clock
// - polarity and phase choose capture edge
// - phase one second edge, phase zero first
// - select low in master: fault, drop modes
// - overrun keeps old byte, clears on status read
// - write during transfer dropped, collision flagged
module spi_master_slave_port (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// control bits
	input wire logic i_port_enable_bit,
	input wire logic i_master_mode_bit,
	input wire logic i_clk_polarity,
	input wire logic i_clk_phase,
	input wire logic [2:0] i_clock_rate_field,
	input wire logic i_soft_select_manage,
	input wire logic i_soft_select_level,
	input wire logic i_transfer_irq_enable,
	input wire logic i_cpu_irq_mask,
	// register access strobes
	input wire logic i_ctrl_wr,
	input wire logic i_status_access,
	input wire logic i_data_wr,
	input wire logic [7:0] i_data_wdata,
	input wire logic i_data_rd,
	output logic [7:0] o_data_rdata,
	// status
	output logic o_transfer_done_flag,
	output logic o_mode_fault_flag,
	output logic o_overrun_flag,
	output logic o_write_collision_flag,
	output logic o_port_enable,
	output logic o_master_mode,
	output logic o_irq,
	// pins
	input wire logic i_ss_n,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	input wire logic i_mosi,
	output logic o_mosi,
	output logic o_mosi_oe,
	input wire logic i_miso,
	output logic o_miso,
	output logic o_miso_oe
);
	typedef struct packed {
		spi_port_pkg::shift_state_t fsm;
		logic [7:0] shift;
		logic [7:0] rxbuf;
		logic [3:0] bits;
		logic [7:0] div;
		logic sample;
		logic sck_prev;
		logic busy;
		logic done;
		logic stat_seen;
		logic mode_fault_flag;
		logic mode_fault_flag_seen;
		logic overrun_flag;
		logic write_collision_flag;
		logic write_collision_flag_seen;
		logic en;
		logic master_mode_bit;
		logic irq;
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} port_state_t;
	port_state_t st_q, st_d;
	// fifo between data writes and the shifter
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_pop;
	logic fifo_push;
	logic sel_int;
	logic [7:0] half_div;
	logic sck_edge;
	logic lead_edge;
	logic sin;
	logic finish;
	logic wr_ok;
	logic clr_step;
	byte_fifo #(
		.WIDTH(spi_port_pkg::DATA_W),
		.DEPTH(spi_port_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_flush(!st_q.en),
		.i_valid(fifo_push),
		.o_ready(fifo_in_ready),
		.i_data(i_data_wdata),
		.o_valid(fifo_out_valid),
		.i_ready(fifo_pop),
		.o_data(fifo_out_data)
	);
	// rate decode; codes 6 and 7 fall back to slowest
	always_comb
	begin
		case (i_clock_rate_field)
			3'h0: half_div = spi_port_pkg::HALF_DIV_0;
			3'h1: half_div = spi_port_pkg::HALF_DIV_1;
			3'h2: half_div = spi_port_pkg::HALF_DIV_2;
			3'h3: half_div = spi_port_pkg::HALF_DIV_3;
			3'h4: half_div = spi_port_pkg::HALF_DIV_4;
			default: half_div = spi_port_pkg::HALF_DIV_5;
		endcase
	end
	// next-state logic for the whole port
	always_comb
	begin
		st_d = st_q;
		sel_int = i_soft_select_manage ? i_soft_select_level : i_ss_n;
		sin = st_q.master_mode_bit ? i_miso : i_mosi;
		// collision: write while shifting or slave selected with phase zero mid-byte (bits not zero)
		wr_ok = i_data_wr && !(st_q.done && !st_q.stat_seen);
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		sck_edge = 1'b0;
		lead_edge = 1'b0;
		finish = 1'b0;
		clr_step = 1'b0;
		if (wr_ok)
		begin
			if (st_q.busy || (!st_q.master_mode_bit && !sel_int && !i_clk_phase && st_q.bits != 4'h0))
				st_d.write_collision_flag = 1'b1;
			else
				fifo_push = fifo_in_ready;
		end
		// enable and master follow control writes; blocked by fault
		if (i_ctrl_wr)
		begin
			if (!st_q.mode_fault_flag || st_q.mode_fault_flag_seen)
			begin
				st_d.en = i_port_enable_bit;
				st_d.master_mode_bit = i_master_mode_bit;
			end
			if (st_q.mode_fault_flag_seen)
			begin
				st_d.mode_fault_flag = 1'b0;
				st_d.mode_fault_flag_seen = 1'b0;
			end
		end
		if (st_q.master_mode_bit && st_q.en && !sel_int)
		begin
			st_d.mode_fault_flag = 1'b1;
			st_d.en = 1'b0;
			st_d.master_mode_bit = 1'b0;
		end
		// master: internal divider makes the clock
		if (st_q.en && st_q.master_mode_bit)
		begin
			case (st_q.fsm)
				spi_port_pkg::ST_IDLE:
				begin
					st_d.sck_o = i_clk_polarity;
					if (fifo_out_valid)
					begin
						fifo_pop = 1'b1;
						st_d.shift = fifo_out_data;
						st_d.mosi_o = fifo_out_data[7];
						st_d.busy = 1'b1;
						st_d.bits = 4'h0;
						st_d.div = 8'h01;
						st_d.fsm = spi_port_pkg::ST_LEAD;
					end
				end
				spi_port_pkg::ST_LEAD, spi_port_pkg::ST_TRAIL:
				begin
					st_d.div = st_q.div + 8'h01;
					if (st_q.div == half_div)
					begin
						st_d.div = 8'h01;
						st_d.sck_o = !st_q.sck_o;
						sck_edge = 1'b1;
						lead_edge = st_q.fsm == spi_port_pkg::ST_LEAD;
						st_d.fsm = lead_edge ? spi_port_pkg::ST_TRAIL : spi_port_pkg::ST_LEAD;
					end
				end
				default: st_d.fsm = spi_port_pkg::ST_IDLE;
			endcase
		end
		else
		begin
			st_d.fsm = spi_port_pkg::ST_IDLE;
			st_d.sck_o = i_clk_polarity;
			// slave: watch master clock edges while selected
			if (st_q.en && !sel_int)
			begin
				if (!st_q.busy && fifo_out_valid)
				begin
					fifo_pop = 1'b1;
					st_d.shift = fifo_out_data;
					st_d.miso_o = fifo_out_data[7];
				end
				if (i_sck != st_q.sck_prev)
				begin
					sck_edge = 1'b1;
					lead_edge = i_sck != i_clk_polarity;
					st_d.busy = 1'b1;
				end
			end
			else if (st_q.en)
			begin
				// select high ends a byte frame; idle state
				st_d.bits = 4'h0;
				st_d.busy = 1'b0;
			end
		end
		st_d.sck_prev = i_sck;
		// capture on first edge for phase zero, second for phase one
		if (sck_edge)
		begin
			if (lead_edge != i_clk_phase)
				st_d.sample = sin;
			// phase one: msb already stands, so the first leading edge keeps it
			else if (!(lead_edge && st_q.bits == 4'h0 && i_clk_phase))
			begin
				st_d.shift = {st_q.shift[6:0], st_q.sample};
				st_d.mosi_o = st_q.shift[6];
				st_d.miso_o = st_q.shift[6];
			end
			if (lead_edge == i_clk_phase)
			begin
				if (!i_clk_phase && st_q.bits == 4'h0 && lead_edge)
					st_d.bits = st_q.bits;
				else
					st_d.bits = st_q.bits + 4'h1;
			end
			// eighth trailing edge ends the byte; phase one counts on leading edges
			if (!lead_edge && st_q.bits == spi_port_pkg::BIT_CNT_LAST + (i_clk_phase ? 4'h1 : 4'h0))
				finish = 1'b1;
		end
		if (finish)
		begin
			st_d.busy = 1'b0;
			st_d.bits = 4'h0;
			if (st_q.master_mode_bit)
				st_d.fsm = spi_port_pkg::ST_IDLE;
			if (st_q.done)
				st_d.overrun_flag = 1'b1;
			else
				// phase one captures its last bit on this very edge
				st_d.rxbuf = {st_q.shift[6:0], i_clk_phase ? sin : st_q.sample};
		end
		// status access arms clearing sequences
		if (i_status_access)
		begin
			if (st_q.done)
				st_d.stat_seen = 1'b1;
			if (st_q.mode_fault_flag)
				st_d.mode_fault_flag_seen = 1'b1;
			if (st_q.write_collision_flag)
				st_d.write_collision_flag_seen = 1'b1;
			st_d.overrun_flag = 1'b0;
		end
		clr_step = st_q.stat_seen && (i_data_rd || (!st_q.master_mode_bit && i_data_wr));
		if (clr_step)
		begin
			st_d.done = 1'b0;
			st_d.stat_seen = 1'b0;
		end
		if (st_q.write_collision_flag_seen && i_data_rd)
		begin
			st_d.write_collision_flag = 1'b0;
			st_d.write_collision_flag_seen = 1'b0;
		end
		// done set wins over clear; on finish, overrun survives a status access only if already set
		if (finish)
			st_d.done = 1'b1;
		if (finish && st_q.overrun_flag)
			st_d.overrun_flag = 1'b1;
		st_d.irq = (st_d.done || st_d.mode_fault_flag || st_d.overrun_flag) && i_transfer_irq_enable && !i_cpu_irq_mask;
		st_d.sck_oe = st_d.en && st_d.master_mode_bit;
		st_d.mosi_oe = st_d.en && st_d.master_mode_bit;
		st_d.miso_oe = st_d.en && !st_d.master_mode_bit && !sel_int;
	end
	// register state
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign o_data_rdata = st_q.rxbuf;
	assign o_transfer_done_flag = st_q.done;
	assign o_mode_fault_flag = st_q.mode_fault_flag;
	assign o_overrun_flag = st_q.overrun_flag;
	assign o_write_collision_flag = st_q.write_collision_flag;
	assign o_port_enable = st_q.en;
	assign o_master_mode = st_q.master_mode_bit;
	assign o_irq = st_q.irq;
	assign o_sck = st_q.sck_o;
	assign o_sck_oe = st_q.sck_oe;
	assign o_mosi = st_q.mosi_o;
	assign o_mosi_oe = st_q.mosi_oe;
	assign o_miso = st_q.miso_o;
	assign o_miso_oe = st_q.miso_oe;
	// checks
	AST_FAULT_DROPS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_q.master_mode_bit && st_q.en && !sel_int) |=> (st_q.mode_fault_flag && !st_q.en && !st_q.master_mode_bit))
		else $error("fault did not drop modes");
	AST_IRQ_GATE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_q.irq |-> $past(i_transfer_irq_enable) && !$past(i_cpu_irq_mask)))
		else $error("irq without enable");
	AST_DONE_STICKY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_q.done && !st_q.stat_seen) |=> st_q.done)
		else $error("done cleared without status access");
	AST_OVR_KEEPS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(finish && st_q.done) |=> $stable(st_q.rxbuf))
		else $error("overrun replaced buffer");
	AST_WRITE_COLLISION_FLAG_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_data_wr && st_q.busy && !(st_q.done && !st_q.stat_seen)) |=> st_q.write_collision_flag)
		else $error("collision not flagged");
	AST_IDLE_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		($past(i_rst_n) && st_q.fsm == spi_port_pkg::ST_IDLE && $stable(i_clk_polarity))
		|-> st_q.sck_o == i_clk_polarity)
		else $error("idle level");
	AST_MASTER_START: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st_q.en && st_q.master_mode_bit && sel_int && st_q.fsm == spi_port_pkg::ST_IDLE
		&& fifo_out_valid) |=> st_q.busy)
		else $error("master did not start");
	AST_DONE_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		finish |=> st_q.done && !st_q.busy)
		else $error("done not set at end");
	COV_MASTER: cover property (@(posedge i_core_clk) finish && st_q.master_mode_bit);
	COV_SLAVE: cover property (@(posedge i_core_clk) finish && !st_q.master_mode_bit);
	COV_OVR: cover property (@(posedge i_core_clk) st_q.overrun_flag);
endmodule : spi_master_slave_port

// ===== spi_port_pkg.sv
package spi_port_pkg;
	// shift width and divider selection
	localparam int unsigned DATA_W = 8;
	localparam int unsigned RATE_W = 3;
	localparam logic [3:0] BIT_CNT_LAST = 4'h7;
	// half-period of serial clock in core cycles per rate code (fastest is /4)
	localparam logic [7:0] HALF_DIV_0 = 8'h02;
	localparam logic [7:0] HALF_DIV_1 = 8'h04;
	localparam logic [7:0] HALF_DIV_2 = 8'h08;
	localparam logic [7:0] HALF_DIV_3 = 8'h10;
	localparam logic [7:0] HALF_DIV_4 = 8'h20;
	localparam logic [7:0] HALF_DIV_5 = 8'h40;
	// tx fifo shape
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} shift_state_t;
endpackage : spi_port_pkg

// ===== tb.sv
`timescale 1ns/10ps
// master-mode bench against the far slave model, plus one slave-mode test
module tb;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic en = 1'b0, master_mode_bit = 1'b0, cpol = 1'b0, cpha = 1'b0, soft_select_manage = 1'b1, soft_select_level = 1'b1;
	logic irq_en = 1'b1, mask = 1'b0, ctrl_wr = 1'b0, st_acc = 1'b0, d_wr = 1'b0;
	logic d_rd = 1'b0, ss_n = 1'b1, sel_n = 1'b1;
	logic [2:0] rate = 3'h0;
	logic [7:0] d_wdata = 8'h00, stx = 8'h00;
	logic [7:0] rdata, srx;
	logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe, s_miso;
	logic done, mode_fault_flag, overrun_flag, write_collision_flag, pen, pmst, irq;
	logic m_drv = 1'b0, m_sck = 1'b0, m_mosi = 1'b0; // bench as external master
	wire sck_w = sck_oe ? sck : (m_drv ? m_sck : cpol); // pulled to the idle level
	wire mosi_w = mosi_oe ? mosi : (m_drv ? m_mosi : 1'b1); // pull-up when released
	wire miso_w = miso_oe ? miso : s_miso; // separate data lines, full duplex
	int err_count = 0, n_checks = 0, cycles = 0;
	// free running core clock
	always #5 i_core_clk = ~i_core_clk;
	spi_master_slave_port spi_master_slave_port_inst (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_port_enable_bit(en),
		.i_master_mode_bit(master_mode_bit), .i_clk_polarity(cpol), .i_clk_phase(cpha),
		.i_clock_rate_field(rate), .i_soft_select_manage(soft_select_manage), .i_soft_select_level(soft_select_level),
		.i_transfer_irq_enable(irq_en), .i_cpu_irq_mask(mask), .i_ctrl_wr(ctrl_wr),
		.i_status_access(st_acc), .i_data_wr(d_wr), .i_data_wdata(d_wdata),
		.i_data_rd(d_rd), .o_data_rdata(rdata), .o_transfer_done_flag(done),
		.o_mode_fault_flag(mode_fault_flag), .o_overrun_flag(overrun_flag), .o_write_collision_flag(write_collision_flag),
		.o_port_enable(pen), .o_master_mode(pmst), .o_irq(irq), .i_ss_n(ss_n),
		.i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi),
		.o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe));
	spi_far_slave spi_far_slave_inst (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(sel_n),
		.i_cpha(cpha), .i_tx(stx), .o_miso(s_miso), .o_rx(srx));
	// verdict and end of run
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// one comparison, counted
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one-cycle register strobes: ctrl, status, data write, data read
	task strobe(input logic [3:0] m);
		@(posedge i_core_clk);
		{ctrl_wr, st_acc, d_wr, d_rd} <= m;
		@(posedge i_core_clk);
		{ctrl_wr, st_acc, d_wr, d_rd} <= 4'h0;
		@(posedge i_core_clk);
		#1;
	endtask : strobe
	// disable, set timing, soft select high, then enable as master
	task setup(input logic p, input logic h, input logic [2:0] r);
		@(posedge i_core_clk);
		en <= 1'b0;
		master_mode_bit <= 1'b0;
		mask <= 1'b0;
		strobe(4'h8);
		@(posedge i_core_clk);
		{cpol, cpha, rate, soft_select_manage, soft_select_level} <= {p, h, r, 2'b11};
		strobe(4'h4);
		@(posedge i_core_clk);
		en <= 1'b1;
		master_mode_bit <= 1'b1;
		strobe(4'h8);
		check({6'h00, pen, pmst}, 8'h03);
	endtask : setup
	// one byte; optional colliding write mid-byte
	task xfer(input logic [7:0] tx, input logic [7:0] sv, input logic coll,
		input logic ovr_e, input logic [7:0] rd_e);
		int e;
		int k;
		int h;
		logic prev;
		@(posedge i_core_clk);
		stx <= sv;
		d_wdata <= tx;
		@(posedge i_core_clk);
		sel_n <= 1'b0;
		strobe(4'h2);
		e = 0;
		k = 0;
		h = 0;
		prev = sck_w;
		while (e < 16 && k < 3000)
		begin
			@(posedge i_core_clk);
			d_wr <= coll && k == 6;
			if (k == 6) d_wdata <= ~tx;
			#1;
			k++;
			if (e == 1) h++;
			if (sck_w !== prev)
			begin
				e++;
				prev = sck_w;
			end
		end
		repeat (2) @(posedge i_core_clk);
		#1;
		check(8'(h), (rate > 3'h5) ? 8'h40 : 8'h02 << rate);
		check(srx, tx);
		check(rdata, rd_e);
		check({7'h00, done}, 8'h01);
		check({7'h00, irq}, {7'h00, irq_en & ~mask});
		check({7'h00, write_collision_flag}, {7'h00, coll});
		check({7'h00, overrun_flag}, {7'h00, ovr_e});
		@(posedge i_core_clk);
		sel_n <= 1'b1;
	endtask : xfer
	// status access then data read
	task clear_done;
		strobe(4'h4);
		strobe(4'h1);
		check({6'h00, done, write_collision_flag}, 8'h00);
	endtask : clear_done
	// all four timing modes, rate codes 0,2,4,6, mask both ways
	task t_modes;
		for (int m = 0; m < 4; m++)
		begin
			setup(m[1], m[0], 3'(m * 2));
			@(posedge i_core_clk);
			mask <= m[0];
			xfer(8'ha5 ^ 8'(m), 8'h3c + 8'(m), 1'b0, 1'b0, 8'h3c + 8'(m));
			clear_done;
		end
		$display("test modes done");
	endtask : t_modes
	// blocked write, partial clear, collision
	task t_done;
		int e;
		setup(1'b0, 1'b0, 3'h0);
		xfer(8'h96, 8'h69, 1'b0, 1'b0, 8'h69);
		strobe(4'h2);
		e = 0;
		repeat (40)
		begin
			@(posedge i_core_clk);
			#1;
			if (sck_w !== 1'b0) e++;
		end
		check(8'(e), 8'h00);
		strobe(4'h1);
		check({7'h00, done}, 8'h01);
		clear_done;
		xfer(8'hc3, 8'h5a, 1'b1, 1'b0, 8'h5a);
		clear_done;
		$display("test done_flag done");
	endtask : t_done
	// second byte lands before done clears
	task t_ovr;
		setup(1'b1, 1'b1, 3'h6);
		xfer(8'h0f, 8'h11, 1'b0, 1'b0, 8'h11);
		strobe(4'h4);
		xfer(8'hf0, 8'h22, 1'b0, 1'b1, 8'h11);
		strobe(4'h4);
		check({7'h00, overrun_flag}, 8'h00);
		clear_done;
		$display("test overrun done");
	endtask : t_ovr
	// soft select hides the pin; pin low then faults
	task t_mode_fault_flag;
		@(posedge i_core_clk);
		ss_n <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		#1;
		check({6'h00, mode_fault_flag, pen}, 8'h01);
		@(posedge i_core_clk);
		soft_select_manage <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1;
		check({4'h0, mode_fault_flag, pen, pmst, irq}, 8'h09);
		@(posedge i_core_clk);
		ss_n <= 1'b1;
		strobe(4'h8);
		check({6'h00, mode_fault_flag, pen}, 8'h02);
		strobe(4'h4);
		strobe(4'h8);
		check({5'h00, mode_fault_flag, pen, pmst}, 8'h03);
		$display("test mode_fault done");
	endtask : t_mode_fault_flag
	// bench clocks the design as slave, mode 0, clock high for 4 cycles and low for 5
	task t_slave;
		logic [7:0] got;
		logic [7:0] mtx;
		got = 8'h00;
		mtx = 8'hb4;
		@(posedge i_core_clk);
		en <= 1'b0;
		master_mode_bit <= 1'b0;
		strobe(4'h8);
		@(posedge i_core_clk);
		{cpol, cpha, soft_select_manage, soft_select_level} <= 4'b0010;
		m_drv <= 1'b1;
		strobe(4'h4);
		@(posedge i_core_clk);
		en <= 1'b1;
		strobe(4'h8);
		check({6'h00, pen, pmst}, 8'h02);
		@(posedge i_core_clk);
		d_wdata <= 8'h5e;
		strobe(4'h2);
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge i_core_clk);
			m_mosi <= mtx[i];
			repeat (4) @(posedge i_core_clk);
			got = {got[6:0], miso_w};
			m_sck <= 1'b1;
			repeat (4) @(posedge i_core_clk);
			m_sck <= 1'b0;
		end
		repeat (3) @(posedge i_core_clk);
		#1;
		check(got, 8'h5e);
		check(rdata, 8'hb4);
		check({7'h00, done}, 8'h01);
		strobe(4'h4);
		strobe(4'h2);
		check({7'h00, done}, 8'h00);
		@(posedge i_core_clk);
		m_drv <= 1'b0;
		$display("test slave done");
	endtask : t_slave
	// hang guard
	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run();
		end
	end
	// main sequence
	initial
	begin
		repeat (12) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		#1;
		check({done, mode_fault_flag, overrun_flag, write_collision_flag, pen, pmst, irq, sck_oe}, 8'h00);
		t_modes();
		t_done();
		t_ovr();
		t_mode_fault_flag();
		t_slave();
		complete_run();
	end
endmodule : tb
